// ---- verilog/sot_pkg.sv ----
// Package of constants and types for the stepout and over-temperature status block
package sot_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] SOT_CTRL_OFS     = 32'h0000_0000;
    localparam logic [31:0] SOT_BAND_OFS     = 32'h0000_0004;
    localparam logic [31:0] SOT_WARN_OFS     = 32'h0000_0008;
    localparam logic [31:0] SOT_FLAGS_OFS    = 32'h0000_000c;
    localparam logic [31:0] SOT_IRQ_STAT_OFS = 32'h0000_0010;
    localparam logic [31:0] SOT_IRQ_MASK_OFS = 32'h0000_0014;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int SOT_CTRL_W  = 4;
    localparam int SOT_FLAG_W  = 2;
    localparam int SOT_POS_W   = 32;
    localparam int SOT_TEMP_W  = 16;
    localparam int SOT_FLAG_STP_BIT  = 0;
    localparam int SOT_FLAG_TEMP_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [SOT_CTRL_W-1:0] SOT_CTRL_RST = 4'hc;
    localparam logic [SOT_POS_W-1:0]  SOT_BAND_RST = 32'h0000_0064;
    localparam logic [SOT_TEMP_W-1:0] SOT_WARN_RST = 16'h0050;
    localparam logic [SOT_FLAG_W-1:0] SOT_FLAG_RST = 2'h0;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] SOT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SOT_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned SOT_CLK_HZ       = 40000000;
    localparam int unsigned SOT_SETTLE_MS    = 500;
    localparam int unsigned SOT_SETTLE_CYC   = SOT_SETTLE_MS * (SOT_CLK_HZ / 1000);
    localparam int          SOT_CNT_W        = 25;

    // Control fields, bit 0 first from the bottom
    typedef struct packed {
        logic overtemp_polarity;
        logic stepout_polarity;
        logic self_correction_enable;
        logic stepout_detect_enable;
    } sot_ctrl_s;

    typedef struct packed {
        logic overtemp_flag;
        logic stepout_flag;
    } sot_flags_s;

endpackage : sot_pkg

// ---- verilog/sot_status.sv ----
// Stepout and over-temperature status flags with AXI4-Lite registers
//
// Summary of operation
// - Read-only stepout flag, 1 means misstep
// - Stepout flag always mirrors stepout output state
// - Stepout detection only with encoder attached
// - Assert when deviation reaches stepout band
// - Detection disabled keeps stepout output inactive
// - Stepout pin level chosen by its polarity
// - Off unexcited; allowed after 500 ms excited
// - Stepout held off during homing
// - Never asserted while self correction enabled
// - Read-only over-temperature flag, 1 means warning
// - Warning set while temperature exceeds level
// - Over-temperature pin level chosen by polarity
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module sot_status
    import sot_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SOT_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    // AXI4-Lite write address and data
    input  wire logic                  s_axi_awvalid_in,
    output logic                       s_axi_awready_out,
    input  wire logic [31:0]           s_axi_awaddr_in,
    input  wire logic                  s_axi_wvalid_in,
    output logic                       s_axi_wready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    output logic [1:0]                 s_axi_bresp_out,
    // AXI4-Lite read
    input  wire logic                  s_axi_arvalid_in,
    output logic                       s_axi_arready_out,
    input  wire logic [31:0]           s_axi_araddr_in,
    output logic                       s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    output logic [31:0]                s_axi_rdata_out,
    output logic [1:0]                 s_axi_rresp_out,
    // Motion and sensing inputs, same clock
    input  wire logic [SOT_POS_W-1:0]  encoder_count_in,
    input  wire logic [SOT_POS_W-1:0]  command_position_in,
    input  wire logic                  motor_excited_in,
    input  wire logic                  homing_active_in,
    input  wire logic [SOT_TEMP_W-1:0] drive_temperature_in,
    // Encoder presence pin, asynchronous
    input  wire logic                  encoder_present_in,
    // Status pins and interrupt
    output logic                       stepout_output_out,
    output logic                       overtemp_output_out,
    output logic                       irq_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [SOT_POS_W-1:0] abs_diff(input logic [SOT_POS_W-1:0] a,
                                                     input logic [SOT_POS_W-1:0] b);
        logic [SOT_POS_W-1:0] d;
        d = a - b;
        return d[SOT_POS_W-1] ? (~d + 32'h0000_0001) : d;
    endfunction : abs_diff
    // Upper address bits must be zero, low two bits ignored
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
        return {addr[31:2], 2'h0} == ofs;
    endfunction : hit
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sot_ctrl_s                 ctrl_q,       ctrl_d;
    logic [SOT_POS_W-1:0]      band_q,       band_d;
    logic [SOT_TEMP_W-1:0]     warn_q,       warn_d;
    sot_flags_s                flags_q,      flags_d;
    logic [SOT_FLAG_W-1:0]     irq_stat_q,   irq_stat_d;
    logic [SOT_FLAG_W-1:0]     irq_mask_q,   irq_mask_d;
    logic [SOT_CNT_W-1:0]      settle_cnt_q, settle_cnt_d;
    logic                      stp_pin_q,    stp_pin_d;
    logic                      tmp_pin_q,    tmp_pin_d;
    logic                      enc_meta_q;
    logic                      enc_sync_q;
    logic                      aw_held_q,    aw_held_d;
    logic                      w_held_q,     w_held_d;
    logic [31:0]               awaddr_q,     awaddr_d;
    logic [31:0]               wdata_q,      wdata_d;
    logic [3:0]                wstrb_q,      wstrb_d;
    logic                      bvalid_q,     bvalid_d;
    logic [1:0]                bresp_q,      bresp_d;
    logic                      rvalid_q,     rvalid_d;
    logic [31:0]               rdata_q,      rdata_d;
    logic [1:0]                rresp_q,      rresp_d;
    logic                      settle_done;
    logic                      gates_ok;
    logic                      band_hit;
    logic                      temp_over;
    logic [SOT_FLAG_W-1:0]     events;

    // ------------------------------------------------------------------
    // Encoder presence synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enc_meta_q <= 1'b0;
            enc_sync_q <= 1'b0;
        end else begin
            enc_meta_q <= encoder_present_in;
            enc_sync_q <= enc_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Flag logic
    // ------------------------------------------------------------------
    assign settle_done = settle_cnt_q == SOT_CNT_W'(SETTLE_CYCLES);
    assign band_hit    = abs_diff(encoder_count_in, command_position_in) >= band_q;
    assign temp_over   = drive_temperature_in > warn_q;
    // Every condition that forces the stepout indication off
    assign gates_ok    = enc_sync_q
                       && ctrl_q.stepout_detect_enable
                       && motor_excited_in && settle_done
                       && !homing_active_in
                       && !ctrl_q.self_correction_enable;
    always_comb begin
        settle_cnt_d = settle_cnt_q;
        if (!motor_excited_in) begin
            settle_cnt_d = '0;
        end else if (!settle_done) begin
            settle_cnt_d = settle_cnt_q + 1'b1;
        end
        flags_d.stepout_flag  = gates_ok && band_hit;
        flags_d.overtemp_flag = temp_over;
        // Pin and flag load from the same next value, so they never disagree
        stp_pin_d = flags_d.stepout_flag ~^ ctrl_q.stepout_polarity;
        tmp_pin_d = flags_d.overtemp_flag ~^ ctrl_q.overtemp_polarity;
        events    = flags_d & ~flags_q;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            settle_cnt_q <= '0;
            flags_q      <= SOT_FLAG_RST;
            stp_pin_q    <= ~SOT_CTRL_RST[2];
            tmp_pin_q    <= ~SOT_CTRL_RST[3];
        end else begin
            settle_cnt_q <= settle_cnt_d;
            flags_q      <= flags_d;
            stp_pin_q    <= stp_pin_d;
            tmp_pin_q    <= tmp_pin_d;
        end
    end
    assign stepout_output_out  = stp_pin_q;
    assign overtemp_output_out = tmp_pin_q;
    assign irq_out             = |(irq_stat_q & irq_mask_q);
    // ------------------------------------------------------------------
    // AXI4-Lite slave and registers
    // ------------------------------------------------------------------
    assign s_axi_awready_out = !aw_held_q;
    assign s_axi_wready_out  = !w_held_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;

    always_comb begin
        logic [31:0] nv;
        logic [SOT_FLAG_W-1:0] clr;
        nv         = 32'h0;
        clr        = '0;
        ctrl_d     = ctrl_q;
        band_d     = band_q;
        warn_d     = warn_q;
        irq_mask_d = irq_mask_q;
        aw_held_d  = aw_held_q;
        w_held_d   = w_held_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        rvalid_d   = rvalid_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        if (s_axi_awvalid_in && !aw_held_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_held_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata_in;
            wstrb_d  = s_axi_wstrb_in;
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
        // Write fires once both halves are held and the last response is gone
        if (aw_held_q && w_held_q && !bvalid_q) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = SOT_RESP_OKAY;
            if (hit(awaddr_q, SOT_CTRL_OFS)) begin
                nv     = merge({28'h0, ctrl_q}, wdata_q, wstrb_q);
                ctrl_d = nv[SOT_CTRL_W-1:0];
            end else if (hit(awaddr_q, SOT_BAND_OFS)) begin
                band_d = merge(band_q, wdata_q, wstrb_q);
            end else if (hit(awaddr_q, SOT_WARN_OFS)) begin
                nv     = merge({16'h0, warn_q}, wdata_q, wstrb_q);
                warn_d = nv[SOT_TEMP_W-1:0];
            end else if (hit(awaddr_q, SOT_FLAGS_OFS)) begin
                nv = 32'h0;
            end else if (hit(awaddr_q, SOT_IRQ_STAT_OFS)) begin
                nv  = merge(32'h0, wdata_q, wstrb_q);
                clr = nv[SOT_FLAG_W-1:0];
            end else if (hit(awaddr_q, SOT_IRQ_MASK_OFS)) begin
                nv         = merge({30'h0, irq_mask_q}, wdata_q, wstrb_q);
                irq_mask_d = nv[SOT_FLAG_W-1:0];
            end else begin
                bresp_d = SOT_RESP_SLVERR;
            end
        end
        // A new event outranks a clear in the same cycle
        irq_stat_d = (irq_stat_q & ~clr) | events;
        if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = SOT_RESP_OKAY;
            if (hit(s_axi_araddr_in, SOT_CTRL_OFS)) begin
                rdata_d = {28'h0, ctrl_q};
            end else if (hit(s_axi_araddr_in, SOT_BAND_OFS)) begin
                rdata_d = band_q;
            end else if (hit(s_axi_araddr_in, SOT_WARN_OFS)) begin
                rdata_d = {16'h0, warn_q};
            end else if (hit(s_axi_araddr_in, SOT_FLAGS_OFS)) begin
                rdata_d = {30'h0, flags_q};
            end else if (hit(s_axi_araddr_in, SOT_IRQ_STAT_OFS)) begin
                rdata_d = {30'h0, irq_stat_q};
            end else if (hit(s_axi_araddr_in, SOT_IRQ_MASK_OFS)) begin
                rdata_d = {30'h0, irq_mask_q};
            end else begin
                rdata_d = 32'h0;
                rresp_d = SOT_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q     <= SOT_CTRL_RST;
            band_q     <= SOT_BAND_RST;
            warn_q     <= SOT_WARN_RST;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            awaddr_q   <= 32'h0;
            wdata_q    <= 32'h0;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= SOT_RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0;
            rresp_q    <= SOT_RESP_OKAY;
        end else begin
            ctrl_q     <= ctrl_d;
            band_q     <= band_d;
            warn_q     <= warn_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            aw_held_q  <= aw_held_d;
            w_held_q   <= w_held_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    pin_mirror_a: assert property (
        stepout_output_out == ($past(ctrl_q.stepout_polarity) ? flags_q.stepout_flag
                                                              : !flags_q.stepout_flag))
        else $error("stepout pin and flag disagree");
    temp_pin_a: assert property (
        overtemp_output_out == (flags_q.overtemp_flag ~^ $past(ctrl_q.overtemp_polarity)))
        else $error("overtemp pin level wrong");
    enc_gate_a: assert property (!enc_sync_q |=> !flags_q.stepout_flag)
        else $error("stepout set without encoder");
    band_hit_a: assert property (gates_ok && band_hit |=> flags_q.stepout_flag)
        else $error("stepout missed a band hit");
    detect_off_a: assert property (!ctrl_q.stepout_detect_enable |=> !flags_q.stepout_flag)
        else $error("stepout set while detection disabled");
    settle_time_a: assert property (
        !motor_excited_in ##1 motor_excited_in [*8] |-> !flags_q.stepout_flag)
        else $error("stepout set before settle time");
    homing_off_a: assert property (homing_active_in |=> !flags_q.stepout_flag)
        else $error("stepout set during homing");
    corr_off_a: assert property (ctrl_q.self_correction_enable |=> !flags_q.stepout_flag)
        else $error("stepout set with self correction");
    temp_flag_a: assert property (##1 flags_q.overtemp_flag == $past(temp_over))
        else $error("overtemp flag does not track temperature");
    irq_sticky_a: assert property (events[SOT_FLAG_STP_BIT] |=> irq_stat_q[SOT_FLAG_STP_BIT])
        else $error("stepout event not latched");
    stepout_seen_c: cover property (flags_q.stepout_flag);
    overtemp_seen_c: cover property (flags_q.overtemp_flag ##1 !flags_q.overtemp_flag);
    irq_seen_c: cover property (irq_out);

endmodule : sot_status

`default_nettype wire

// ---- tb/sot_drive_model.sv ----
// Behavioural motor drive, incremental encoder and temperature source
`timescale 1ns/10ps
`default_nettype none

module sot_drive_model
    import sot_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    // Scenario controls
    input  wire logic [SOT_POS_W-1:0]  dev_in,
    input  wire logic                  excite_in,
    input  wire logic                  home_in,
    input  wire logic                  present_in,
    input  wire logic [SOT_TEMP_W-1:0] temp_in,
    // Towards the block
    output logic [SOT_POS_W-1:0]       encoder_count_out,
    output logic [SOT_POS_W-1:0]       command_position_out,
    output logic                       motor_excited_out,
    output logic                       homing_active_out,
    output logic [SOT_TEMP_W-1:0]      drive_temperature_out,
    output logic                       encoder_present_out
);
    logic [SOT_POS_W-1:0] cmd_d;

    assign cmd_d                 = command_position_out + {31'h0, excite_in};
    assign motor_excited_out     = excite_in;
    assign homing_active_out     = home_in;
    assign drive_temperature_out = temp_in;
    assign encoder_present_out   = present_in;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            command_position_out <= 32'h0000_0000;
            encoder_count_out    <= 32'h0000_0000;
        end else begin
            command_position_out <= cmd_d;
            // Detached encoder leaves its lines toggling, never a stale count
            encoder_count_out    <= present_in ? cmd_d + dev_in : ~encoder_count_out;
        end
    end
endmodule : sot_drive_model

`default_nettype wire

// ---- tb/stepout_and_overtemp_status_tb_top.sv ----
// Self-checking bench for the stepout and over-temperature status block
`timescale 1ns/10ps
`default_nettype none

module stepout_and_overtemp_status_tb_top
    import sot_pkg::*;
;
    // Short settle so the run stays brief
    localparam int unsigned SETTLE = 16;

    typedef struct {
        logic [3:0]  ctrl;
        logic [31:0] d;
        logic        h, p;
        logic [15:0] t;
        logic [1:0]  fl;
    } sot_row_s;

    logic        clk_in, resetn_in;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, dev, enc, cmd;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [15:0] temp, dtemp;
    logic        excite, home, pres, exc_w, home_w, pres_w;
    logic        stp_pin, tmp_pin, irq;
    int          err_total, cmp_count;

    sot_row_s rows [8] = '{
        '{4'h1, 32'h0000_0064, 1'h0, 1'h1, 16'h0050, 2'h1},
        '{4'hd, 32'h0000_0063, 1'h0, 1'h1, 16'h0051, 2'h2},
        '{4'hd, 32'hffff_ff9c, 1'h0, 1'h1, 16'h0000, 2'h1},
        '{4'hc, 32'h0000_00c8, 1'h0, 1'h1, 16'h0000, 2'h0},
        '{4'hf, 32'h0000_00c8, 1'h0, 1'h1, 16'h0000, 2'h0},
        '{4'hd, 32'h0000_00c8, 1'h1, 1'h1, 16'h0000, 2'h0},
        '{4'hd, 32'h0000_00c8, 1'h0, 1'h0, 16'h0000, 2'h0},
        '{4'h5, 32'h0000_0064, 1'h0, 1'h1, 16'h0051, 2'h3}};

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    sot_status #(.SETTLE_CYCLES(SETTLE)) sot_status_inst (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .encoder_count_in(enc), .command_position_in(cmd), .motor_excited_in(exc_w),
        .homing_active_in(home_w), .drive_temperature_in(dtemp), .encoder_present_in(pres_w),
        .stepout_output_out(stp_pin), .overtemp_output_out(tmp_pin), .irq_out(irq));

    sot_drive_model sot_drive_model_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .dev_in(dev), .excite_in(excite),
        .home_in(home), .present_in(pres), .temp_in(temp), .encoder_count_out(enc),
        .command_position_out(cmd), .motor_excited_out(exc_w), .homing_active_out(home_w),
        .drive_temperature_out(dtemp), .encoder_present_out(pres_w));

    // ------------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic hang(input string what);
        err_total++;
        $display("[ERR] %0t wait ran out: %s", $time, what);
        report_and_stop();
    endtask : hang

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_pin(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t pin %b, expected %b", $time, got, exp);
        end
    endtask : chk_pin

    // Ready is looked at mid-cycle, so the handshake edge is never raced
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit         ta, tw, done;
        logic [1:0] r;
        @(posedge clk_in);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk_in);
            ta   = awvalid && awready;
            tw   = wvalid && wready;
            done = bvalid;
            r    = bresp;
            @(posedge clk_in);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) begin
            hang("write");
        end else begin
            chk_word({30'h0, r}, {30'h0, er});
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit          ta, done;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk_in);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk_in);
            ta   = arvalid && arready;
            done = rvalid;
            d    = rdata;
            r    = rresp;
            @(posedge clk_in);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) begin
            hang("read");
        end else begin
            chk_word(d, ed);
            chk_word({30'h0, r}, {30'h0, er});
        end
    endtask : axi_rd

    task automatic set_in(input logic [31:0] d, input logic h, input logic p,
                          input logic [15:0] t, input logic e);
        @(posedge clk_in);
        dev    <= d;
        home   <= h;
        pres   <= p;
        temp   <= t;
        excite <= e;
    endtask : set_in

    task automatic wait_pin(input logic e, input int lim);
        for (int n = 0; n < lim && stp_pin !== e; n++) @(negedge clk_in);
        chk_pin(stp_pin, e);
    endtask : wait_pin

    initial begin
        repeat (20000) @(posedge clk_in);
        hang("run");
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {resetn_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr, dev} = 128'h0;
        {temp, excite, home, pres} = 19'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        axi_rd(SOT_FLAGS_OFS, 32'h0, SOT_RESP_OKAY);
        axi_rd(SOT_CTRL_OFS, 32'h0000_000c, SOT_RESP_OKAY);
        axi_rd(SOT_BAND_OFS, 32'h0000_0064, SOT_RESP_OKAY);
        axi_rd(SOT_WARN_OFS, 32'h0000_0050, SOT_RESP_OKAY);
        axi_rd(SOT_IRQ_MASK_OFS, 32'h0, SOT_RESP_OKAY);
        axi_rd(32'h0000_0018, 32'h0, SOT_RESP_SLVERR);
        axi_wr(SOT_FLAGS_OFS, 32'h0000_0003, SOT_RESP_OKAY);
        axi_rd(SOT_FLAGS_OFS, 32'h0, SOT_RESP_OKAY);
        $display("Reset test done");
        // Settle window, then interrupt raise, mask and clear
        axi_wr(SOT_CTRL_OFS, 32'h0000_000d, SOT_RESP_OKAY);
        set_in(32'h0000_00c8, 1'h0, 1'h1, 16'h0000, 1'h1);
        // Cycle in which the settle count is reached with the pin still low, then the very next one
        repeat (SETTLE) @(posedge clk_in);
        @(negedge clk_in);
        chk_pin(stp_pin, 1'h0);
        wait_pin(1'h1, 1);
        chk_pin(irq, 1'h0);
        axi_wr(SOT_IRQ_MASK_OFS, 32'h0000_0001, SOT_RESP_OKAY);
        @(negedge clk_in);
        chk_pin(irq, 1'h1);
        axi_rd(SOT_IRQ_STAT_OFS, 32'h0000_0001, SOT_RESP_OKAY);
        axi_wr(SOT_IRQ_STAT_OFS, 32'h0000_0001, SOT_RESP_OKAY);
        @(negedge clk_in);
        chk_pin(irq, 1'h0);
        set_in(32'h0000_00c8, 1'h0, 1'h1, 16'h0000, 1'h0);
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk_pin(stp_pin, 1'h0);
        set_in(32'h0000_00c8, 1'h0, 1'h1, 16'h0000, 1'h1);
        repeat (SETTLE + 8) @(posedge clk_in);
        $display("Settle and interrupt test done");
        foreach (rows[i]) begin
            axi_wr(SOT_CTRL_OFS, {28'h0, rows[i].ctrl}, SOT_RESP_OKAY);
            set_in(rows[i].d, rows[i].h, rows[i].p, rows[i].t, 1'h1);
            repeat (8) @(posedge clk_in);
            axi_rd(SOT_FLAGS_OFS, {30'h0, rows[i].fl}, SOT_RESP_OKAY);
            @(negedge clk_in);
            chk_pin(stp_pin, rows[i].fl[0] ~^ rows[i].ctrl[2]);
            chk_pin(tmp_pin, rows[i].fl[1] ~^ rows[i].ctrl[3]);
            $display("Row %0d done", i);
        end
        // Reset in mid-run with the stepout flag up
        set_in(32'h0000_0064, 1'h0, 1'h1, 16'h0000, 1'h1);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(negedge clk_in);
        chk_pin(stp_pin, 1'h0);
        chk_pin(irq, 1'h0);
        @(posedge clk_in);
        resetn_in <= 1'b1;
        axi_rd(SOT_FLAGS_OFS, 32'h0, SOT_RESP_OKAY);
        axi_rd(SOT_CTRL_OFS, 32'h0000_000c, SOT_RESP_OKAY);
        $display("Second reset test done");
        report_and_stop();
    end
endmodule : stepout_and_overtemp_status_tb_top

`default_nettype wire
